// file: rtl/abx_exec.sv
// Purpose: executes add, add with carry, arithmetic shift, bit clear, bit test and
//          relative branch for an 8-bit core, holding accumulator, flags and counter
// Assumes: all inputs come from logic on clk_i; one instruction offered at a time
// Notes:   every instruction takes an accept cycle and an execute cycle; a taken
//          branch adds one flush cycle, a taken skip turns the next instruction into a no-op
`timescale 1ns/10ps

module abx_exec (
  input  wire logic                         clk_i,
  input  wire logic                         reset_i,
  input  wire logic                         instr_valid_i,
  input  wire abx_pkg::abx_op_t             instr_op_i,
  input  wire logic [abx_pkg::ADDR_W-1:0]   instr_addr_i,
  input  wire logic                         instr_dest_i,
  input  wire logic [abx_pkg::BIT_W-1:0]    instr_bit_i,
  input  wire logic [abx_pkg::OFFS_W-1:0]   instr_offset_i,
  input  wire logic                         preload_en_i,
  input  wire logic [abx_pkg::ADDR_W-1:0]   preload_addr_i,
  input  wire logic [abx_pkg::DATA_W-1:0]   preload_data_i,
  output logic                              ready_o,
  output logic                              done_o,
  output logic                              discarded_o,
  output logic      [abx_pkg::DATA_W-1:0]   acc_o,
  output logic                              carry_o,
  output logic                              half_overflow_flag_o,
  output logic                              zero_o,
  output logic      [abx_pkg::PC_W-1:0]     pc_o,
  output logic                              file_wr_o,
  output logic      [abx_pkg::ADDR_W-1:0]   file_addr_o,
  output logic      [abx_pkg::DATA_W-1:0]   file_data_o
);
  import abx_pkg::*;

  typedef enum logic [1:0] {
    ABX_ST_IDLE,
    ABX_ST_EXEC,
    ABX_ST_FLUSH
  } abx_state_t;

  abx_state_t        state;
  abx_state_t        next_state;
  abx_op_t           op;
  logic [ADDR_W-1:0] addr;
  logic              dest;
  logic [BIT_W-1:0]  bit_sel;
  logic [OFFS_W-1:0] offset;
  logic              skip_pending;
  logic [DATA_W-1:0] operand;
  logic              accept;
  logic              discard;

  // combinational results of the execute cycle
  logic [DATA_W:0]     sum9;
  logic [NIBBLE_W:0]   sum5;
  logic                cin;
  logic [DATA_W-1:0]   result;
  logic                writes_result;
  logic                writes_file;
  logic [PC_W-1:0]     jump_target;
  logic                skip_taken;

  ////////////////////////////////////////////////////////////////////////////
  // accept and discard decisions

  assign accept  = (state == ABX_ST_IDLE) && instr_valid_i;
  // a skipped instruction is accepted but runs as a no-op
  assign discard = accept && skip_pending;

  // fields are held for the execute cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      op      <= ABX_OP_NOP;
      addr    <= '0;
      dest    <= DEST_ACC;
      bit_sel <= '0;
      offset  <= '0;
    end else if (accept) begin
      op      <= discard ? ABX_OP_NOP : instr_op_i;
      addr    <= instr_addr_i;
      dest    <= instr_dest_i;
      bit_sel <= instr_bit_i;
      offset  <= instr_offset_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // file storage, written back in the execute cycle or preloaded while idle
  logic              next_file_wr;
  logic [ADDR_W-1:0] next_file_addr;
  logic [DATA_W-1:0] next_file_data;

  abx_file_mem u_file_mem (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .wr_en_i   (next_file_wr),
    .wr_addr_i (next_file_addr),
    .wr_data_i (next_file_data),
    .rd_addr_i (instr_addr_i),
    .rd_data_o (operand)
  );

  ////////////////////////////////////////////////////////////////////////////
  // datapath

  always_comb begin
    cin           = (op == ABX_OP_ADD_ACC_FILE_WITH_CARRY) ? carry_o : 1'b0;
    sum9          = {1'b0, acc_o} + {1'b0, operand} + {{DATA_W{1'b0}}, cin};
    sum5          = {1'b0, acc_o[NIBBLE_W-1:0]} + {1'b0, operand[NIBBLE_W-1:0]}
                    + {{NIBBLE_W{1'b0}}, cin};
    result        = sum9[DATA_W-1:0];
    writes_result = 1'b0;
    skip_taken    = 1'b0;
    unique case (op)
      ABX_OP_ADD_ACC_TO_FILE,
      ABX_OP_ADD_ACC_FILE_WITH_CARRY: begin
        writes_result = 1'b1;
      end
      ABX_OP_ARITH_SHIFT_RIGHT_FILE: begin
        result        = {operand[MSB_POS], operand[DATA_W-1:1]};
        writes_result = 1'b1;
      end
      ABX_OP_BIT_CLEAR_FILE: begin
        result          = operand;
        result[bit_sel] = 1'b0;
      end
      ABX_OP_TEST_BIT_SKIP_IF_ZERO: begin
        skip_taken = ~operand[bit_sel];
      end
      ABX_OP_NOP,
      ABX_OP_RELATIVE_JUMP: begin
      end
    endcase
    // bit clear always writes the file; add and shift follow the destination bit
    writes_file = (op == ABX_OP_BIT_CLEAR_FILE) || (writes_result && dest == DEST_FILE);
  end

  // counter already points past the branch, so add the signed offset to it
  assign jump_target = pc_o + PC_W'({{(PC_W-OFFS_W){offset[OFFS_W-1]}}, offset});

  always_comb begin
    next_file_wr   = preload_en_i && (state == ABX_ST_IDLE);
    next_file_addr = preload_addr_i;
    next_file_data = preload_data_i;
    if (state == ABX_ST_EXEC && writes_file) begin
      next_file_wr   = 1'b1;
      next_file_addr = addr;
      next_file_data = result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  always_comb begin
    next_state = state;
    unique case (state)
      ABX_ST_IDLE:  next_state = accept ? ABX_ST_EXEC : ABX_ST_IDLE;
      // branch spends one more cycle while the fetched word is thrown away
      ABX_ST_EXEC:  next_state = (op == ABX_OP_RELATIVE_JUMP) ? ABX_ST_FLUSH
                                                              : ABX_ST_IDLE;
      ABX_ST_FLUSH: next_state = ABX_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state   <= ABX_ST_IDLE;
      ready_o <= 1'b1;
    end else begin
      state   <= next_state;
      ready_o <= (next_state == ABX_ST_IDLE);
    end
  end

  // skip is remembered until the following instruction is accepted
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      skip_pending <= 1'b0;
    end else if (state == ABX_ST_EXEC && skip_taken) begin
      skip_pending <= 1'b1;
    end else if (accept) begin
      skip_pending <= 1'b0;
    end
  end

  // completion pulses
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      done_o      <= 1'b0;
      discarded_o <= 1'b0;
    end else begin
      done_o      <= (next_state == ABX_ST_IDLE) && (state != ABX_ST_IDLE);
      discarded_o <= discard;
    end
  end

  // program counter steps on every accepted word, jumps after a branch
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pc_o <= PC_RESET;
    end else if (accept) begin
      pc_o <= pc_o + PC_STEP;
    end else if (state == ABX_ST_EXEC && op == ABX_OP_RELATIVE_JUMP) begin
      pc_o <= jump_target;
    end
  end

  // accumulator takes results routed with destination 0
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      acc_o <= ACC_RESET;
    end else if (state == ABX_ST_EXEC && writes_result && dest == DEST_ACC) begin
      acc_o <= result;
    end
  end

  // flags: additions touch all three, shift only carry and zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      carry_o              <= FLAG_RESET;
      half_overflow_flag_o <= FLAG_RESET;
      zero_o               <= FLAG_RESET;
    end else if (state == ABX_ST_EXEC) begin
      if (op == ABX_OP_ADD_ACC_TO_FILE || op == ABX_OP_ADD_ACC_FILE_WITH_CARRY) begin
        carry_o              <= sum9[DATA_W];
        half_overflow_flag_o <= sum5[NIBBLE_W];
        zero_o               <= (result == '0);
      end else if (op == ABX_OP_ARITH_SHIFT_RIGHT_FILE) begin
        carry_o <= operand[0];
        zero_o  <= (result == '0);
      end
    end
  end

  // mirror of file write-back for observation
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      file_wr_o   <= 1'b0;
      file_addr_o <= '0;
      file_data_o <= '0;
    end else begin
      file_wr_o   <= next_file_wr;
      file_addr_o <= next_file_addr;
      file_data_o <= next_file_data;
    end
  end

endmodule

// file: rtl/abx_pkg.sv
// Purpose: shared constants and types for the arithmetic, bit and branch execution block
// Assumes: 8-bit data path, 128 file locations, 15-bit program counter
// Notes:   every width, reset value and encoding used by more than one file lives here
package abx_pkg;

  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ADDR_W   = 7;
  localparam int unsigned BIT_W    = 3;
  localparam int unsigned OFFS_W   = 9;
  localparam int unsigned PC_W     = 15;
  localparam int unsigned FILE_DEPTH = 128;

  localparam logic [DATA_W-1:0] ACC_RESET   = 8'h00;
  localparam logic [PC_W-1:0]   PC_RESET    = 15'h0000;
  localparam logic              FLAG_RESET  = 1'b0;
  localparam logic              DEST_ACC    = 1'b0;
  localparam logic              DEST_FILE   = 1'b1;
  localparam logic [PC_W-1:0]   PC_STEP     = 15'h0001;

  // bit positions inside the result and nibble used by the flags
  localparam int unsigned MSB_POS   = 7;
  localparam int unsigned NIBBLE_W  = 4;

  typedef enum logic [2:0] {
    ABX_OP_NOP,
    ABX_OP_ADD_ACC_TO_FILE,
    ABX_OP_ADD_ACC_FILE_WITH_CARRY,
    ABX_OP_ARITH_SHIFT_RIGHT_FILE,
    ABX_OP_BIT_CLEAR_FILE,
    ABX_OP_TEST_BIT_SKIP_IF_ZERO,
    ABX_OP_RELATIVE_JUMP
  } abx_op_t;

endpackage

// file: rtl/abx_file_mem.sv
// Purpose: file register storage, one write port and one registered read port
// Assumes: write and read share the instruction clock
// Notes:   read data appear one edge after the address; array itself has no reset
`timescale 1ns/10ps
module abx_file_mem (
  input  wire logic                        clk_i,
  input  wire logic                        reset_i,
  input  wire logic                        wr_en_i,
  input  wire logic [abx_pkg::ADDR_W-1:0]  wr_addr_i,
  input  wire logic [abx_pkg::DATA_W-1:0]  wr_data_i,
  input  wire logic [abx_pkg::ADDR_W-1:0]  rd_addr_i,
  output logic      [abx_pkg::DATA_W-1:0]  rd_data_o
);
  import abx_pkg::*;

  logic [DATA_W-1:0] store [FILE_DEPTH];

  // write port, contents undefined until written
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      store[wr_addr_i] <= wr_data_i;
    end
  end

  // registered read keeps the output free of array glitches
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= store[rd_addr_i];
    end
  end

endmodule

// file: dv/abx_exec_assertions.sv
// Purpose: port checks for the execution block
// Assumes: one clock, reset_i async active high
// Notes:   bound to abx_exec from the bench top
`timescale 1ns/10ps
module abx_exec_checker
  import abx_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              reset_i,
  input wire logic              instr_valid_i,
  input wire abx_op_t           instr_op_i,
  input wire logic              instr_dest_i,
  input wire logic [OFFS_W-1:0] instr_offset_i,
  input wire logic              ready_o,
  input wire logic              done_o,
  input wire logic [DATA_W-1:0] acc_o,
  input wire logic              carry_o,
  input wire logic              half_overflow_flag_o,
  input wire logic              zero_o,
  input wire logic [PC_W-1:0]   pc_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  //////////////////////////////////////////////////////////////
  // accept strobes and sign-extended offset
  logic            take;
  logic            jmp;
  logic [PC_W-1:0] sx;
  assign take = ready_o && instr_valid_i;
  assign jmp  = take && instr_op_i == ABX_OP_RELATIVE_JUMP;
  assign sx   = {{(PC_W-OFFS_W){instr_offset_i[OFFS_W-1]}}, instr_offset_i};
  //////////////////////////////////////////////////////////////
  take_drop_a: assert property (take |=> !ready_o)
    else $error("ready stayed high after accept");
  short_cycle_a: assert property (take && !jmp |=> !ready_o ##1 ready_o)
    else $error("plain instruction not two cycles");
  flush_cycle_a: assert property (jmp |=> !ready_o [*2] ##1 ready_o)
    else $error("branch lacks flush cycle");
  jump_target_a: assert property (jmp |-> ##2
      pc_o == $past(pc_o, 2) + PC_STEP + $past(sx, 2))
    else $error("branch target wrong");
  pc_step_a: assert property (take && !jmp |=> pc_o == $past(pc_o) + PC_STEP)
    else $error("counter did not step");
  done_after_a: assert property (take && !jmp |-> ##2 done_o)
    else $error("done pulse missing");
  // flags must survive clear, test and branch
  flags_kept_a: assert property (take && instr_op_i inside {ABX_OP_BIT_CLEAR_FILE,
      ABX_OP_TEST_BIT_SKIP_IF_ZERO, ABX_OP_RELATIVE_JUMP} |-> ##2
      {carry_o, half_overflow_flag_o, zero_o} ==
      $past({carry_o, half_overflow_flag_o, zero_o}, 2))
    else $error("flags changed");
  // a discarded instruction leaves both untouched, hence the escape
  zero_match_a: assert property (take && instr_dest_i == DEST_ACC
      && instr_op_i inside {ABX_OP_ADD_ACC_TO_FILE, ABX_OP_ADD_ACC_FILE_WITH_CARRY,
      ABX_OP_ARITH_SHIFT_RIGHT_FILE} |-> ##2 (zero_o == (acc_o == 8'h00)) ||
      (acc_o == $past(acc_o, 2) && zero_o == $past(zero_o, 2)))
    else $error("zero flag disagrees with result");
endmodule

// file: dv/abx_exec_tb_top.sv
// Purpose: random instruction run against a bench model
// Assumes: file preloaded through the preload port first
// Notes:   one idle cycle between instructions keeps the driver simple
`timescale 1ns/10ps
module abx_exec_tb_top;
  import abx_pkg::*;
  logic        clk_i, reset_i, instr_valid_i, instr_dest_i, preload_en_i, seen_disc;
  abx_op_t     instr_op_i, op;
  logic [6:0]  instr_addr_i, preload_addr_i, file_addr_o;
  logic [2:0]  instr_bit_i;
  logic [8:0]  instr_offset_i, k;
  logic [7:0]  preload_data_i, acc_o, file_data_o, m_acc;
  logic [7:0]  fm [128];
  logic        ready_o, done_o, discarded_o, carry_o, half_overflow_flag_o, zero_o, file_wr_o;
  logic        m_c, m_dc, m_z, m_skip;
  logic [14:0] pc_o, m_pc;
  logic [14:0] wq [$];
  int          bad_count, checks_done, seed;

  abx_exec dut (.clk_i, .reset_i, .instr_valid_i, .instr_op_i, .instr_addr_i, .instr_dest_i,
    .instr_bit_i, .instr_offset_i, .preload_en_i, .preload_addr_i, .preload_data_i, .ready_o,
    .done_o, .discarded_o, .acc_o, .carry_o, .half_overflow_flag_o, .zero_o, .pc_o,
    .file_wr_o, .file_addr_o, .file_data_o);

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [14:0] e, input logic [14:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wait_rdy(input logic lv);
    int n;
    n = 0;
    while (ready_o !== lv) begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > 20) begin
        chk("ready", 15'(lv), 15'(ready_o));
        tally_and_finish();
      end
    end
  endtask

  // write-backs are compared in order at the falling edge, clear of updates
  always @(negedge clk_i) begin
    if (discarded_o === 1'b1) seen_disc = 1'b1;
    if (file_wr_o === 1'b1) begin
      if (wq.size() == 0) chk("spare write", 15'h0000, 15'h7FFF);
      else chk("file write", wq.pop_front(), {file_addr_o, file_data_o});
    end
  end
  //////////////////////////////////////////////////////////////
  task automatic run(input abx_op_t o, input logic [6:0] a, input logic d,
                     input logic [2:0] b, input logic [8:0] kk);
    logic [8:0] s;
    logic [7:0] f, r;
    logic       sk, c, wr;
    f = fm[a];
    r = f;
    wr = 1'b0;
    sk = m_skip;
    m_skip = 1'b0;
    seen_disc = 1'b0;
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_op_i <= o;
    instr_addr_i <= a;
    instr_dest_i <= d;
    instr_bit_i <= b;
    instr_offset_i <= kk;
    wait_rdy(1'b0);
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    #1;
    wait_rdy(1'b1);
    m_pc = m_pc + 15'h0001;
    if (sk) chk("discard", 15'h0001, 15'(seen_disc));
    else case (o)
      ABX_OP_ADD_ACC_TO_FILE, ABX_OP_ADD_ACC_FILE_WITH_CARRY: begin
        c = (o == ABX_OP_ADD_ACC_FILE_WITH_CARRY) ? m_c : 1'b0;
        s = {1'b0, m_acc} + {1'b0, f} + 9'(c);
        m_dc = ({1'b0, m_acc[3:0]} + {1'b0, f[3:0]} + 5'(c)) > 5'h0F;
        m_c = s[8];
        r = s[7:0];
        wr = 1'b1;
      end
      ABX_OP_ARITH_SHIFT_RIGHT_FILE: begin
        r = {f[7], f[7:1]};
        m_c = f[0];
        wr = 1'b1;
      end
      ABX_OP_BIT_CLEAR_FILE: begin
        r[b] = 1'b0;
        fm[a] = r;
        wq.push_back({a, r});
      end
      ABX_OP_TEST_BIT_SKIP_IF_ZERO: m_skip = !f[b];
      ABX_OP_RELATIVE_JUMP: m_pc = m_pc + {{6{kk[8]}}, kk};
      default: ;
    endcase
    if (wr) begin
      m_z = (r == 8'h00);
      if (d == DEST_ACC) m_acc = r;
      else begin
        fm[a] = r;
        wq.push_back({a, r});
      end
    end
    chk("acc", 15'(m_acc), 15'(acc_o));
    chk("carry", 15'(m_c), 15'(carry_o));
    chk("half", 15'(m_dc), 15'(half_overflow_flag_o));
    chk("zero", 15'(m_z), 15'(zero_o));
    chk("pc", m_pc, pc_o);
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h5530;
    bad_count = 0;
    checks_done = 0;
    reset_i = 1'b1;
    {instr_valid_i, instr_dest_i, preload_en_i} = 3'h0;
    instr_op_i = ABX_OP_NOP;
    {instr_addr_i, preload_addr_i, instr_bit_i} = 17'h00000;
    {instr_offset_i, preload_data_i} = 17'h00000;
    {m_acc, m_c, m_dc, m_z, m_skip, m_pc} = 27'h0000000;
    repeat (16) @(posedge clk_i);
    // outputs must sit at their idle values while reset is held
    chk("reset ready", 15'h0001, 15'(ready_o));
    chk("reset flags", 15'h0000, 15'({carry_o, half_overflow_flag_o, zero_o}));
    chk("reset pc", 15'h0000, pc_o);
    chk("reset acc", 15'h0000, 15'(acc_o));
    reset_i <= 1'b0;
    for (int i = 0; i < 128; i++) begin
      @(posedge clk_i);
      fm[i] = 8'($random(seed));
      preload_en_i <= 1'b1;
      preload_addr_i <= 7'(i);
      preload_data_i <= fm[i];
      wq.push_back({7'(i), fm[i]});
    end
    @(posedge clk_i);
    preload_en_i <= 1'b0;
    $display("preload test done");
    // a branch never follows a pending skip: its flush timing would not apply
    for (int i = 0; i < 500; i++) begin
      op = abx_op_t'(3'({$random(seed)} % 7));
      if (m_skip && op == ABX_OP_RELATIVE_JUMP) op = ABX_OP_NOP;
      k = (i % 7 == 6) ? 9'h100 : (i % 7 == 5) ? 9'h0FF : 9'($random(seed));
      run(op, 7'($random(seed)), 1'($random(seed)), 3'($random(seed)), k);
    end
    repeat (4) @(posedge clk_i);
    chk("pending writes", 15'h0000, 15'(wq.size()));
    $display("instruction test done");
    tally_and_finish();
  end
endmodule

bind abx_exec abx_exec_checker chk_u (.clk_i, .reset_i, .instr_valid_i, .instr_op_i,
  .instr_dest_i, .instr_offset_i, .ready_o, .done_o, .acc_o, .carry_o,
  .half_overflow_flag_o, .zero_o, .pc_o);
